// ### logic/osl_block_framer.sv
module osl_block_framer import osl_pkg::*; #(
   parameter int unsigned MAX_SAMPLES = MAX_SAMPLES_DEF,
   parameter int unsigned SLOT_CYCLES = SLOT_CYCLES_DEF,
   parameter int unsigned WPB         = MAX_SAMPLES * VALUES_PER_SAMPLE,
   parameter int unsigned ADDR_W      = $clog2(BANKS * WPB)
) (
   input  wire logic               i_clk,
   input  wire logic               i_reset_n,
   // APB register port
   input  wire logic               i_psel,
   input  wire logic               i_penable,
   input  wire logic               i_pwrite,
   input  wire logic [7:0]         i_paddr,
   input  wire logic [31:0]        i_pwdata,
   output logic                    o_pready,
   output logic [31:0]             o_prdata,
   output logic                    o_pslverr,
   // Samples from the measurement core
   input  wire logic               i_sample_valid,
   input  wire logic [VALUE_W-1:0] i_sample_val0,
   input  wire logic [VALUE_W-1:0] i_sample_val1,
   // Fieldbus side: one fetch pulse per master cycle, then word reads
   input  wire logic               i_pdo_fetch,
   input  wire logic [ADDR_W-1:0]  i_pdo_word,
   output logic [VALUE_W-1:0]      o_pdo_data,
   output logic [SEQ_W-1:0]        o_pdo_seq,
   output logic [SAMP_W-1:0]       o_pdo_samples,
   output logic                    o_pdo_fresh,
   // Two-colour state indicator lamp
   output logic                    o_lamp_green,
   output logic                    o_lamp_red
);
   typedef struct packed {
      osl_fill_t                    fsm;
      logic [SAMP_W-1:0]            cfg_samples;
      osl_comm_t                    comm;
      osl_err_t                     err;
      logic                         enable;
      logic [SAMP_W-1:0]            fill_idx;
      logic [SAMP_W-1:0]            fill_n;
      logic [1:0]                   fill_bank;
      logic [1:0]                   ready_bank;
      logic [1:0]                   read_bank;
      logic                         ready_pend;
      logic [BANKS-1:0][SEQ_W-1:0]  bank_seq;
      logic [BANKS-1:0][SAMP_W-1:0] bank_n;
      logic [SEQ_W-1:0]             seq_ctr;
      logic [SEQ_W-1:0]             drop_ctr;
      logic [SEQ_W-1:0]             rep_ctr;
      logic [31:0]                  prdata;
      logic                         pslverr;
      logic                         fresh;
   } osl_frame_state_t;

   osl_frame_state_t st_reg, st_next;
   logic [VALUE_W-1:0] mem [0:BANKS*WPB-1];
   logic [VALUE_W-1:0] pdo_data_reg;
   logic               wr_en;
   logic               blk_done;

   // Word address of one value of one sample inside a bank
   function automatic logic [ADDR_W-1:0] word_addr(input logic [1:0] bank, input logic [SAMP_W-1:0] idx,
                                                   input int unsigned val);
      return ADDR_W'(int'(bank) * WPB + int'(idx) * VALUES_PER_SAMPLE + val);
   endfunction : word_addr

   // Out-of-range sample counts are clamped instead of refused
   function automatic logic [SAMP_W-1:0] clamp_samples(input logic [SAMP_W-1:0] n);
      if (n == '0) begin
         return SAMP_W'(1);
      end else if (n > SAMP_W'(MAX_SAMPLES)) begin
         return SAMP_W'(MAX_SAMPLES);
      end
      return n;
   endfunction : clamp_samples

   ////////////////////////////////////////////////////////////////////////////
   // Block filling and hand-over
   assign wr_en    = i_sample_valid && st_reg.enable;
   assign blk_done = wr_en && (st_reg.fsm == FILL_RUN) && (st_reg.fill_idx == st_reg.fill_n - 1'b1);

   always_comb begin
      logic       apb_wr;
      logic       apb_rd;
      logic [1:0] old_ready;
      apb_wr = i_psel && i_penable && i_pwrite;
      apb_rd = i_psel && !i_penable && !i_pwrite;
      old_ready = st_reg.ready_bank;
      st_next = st_reg;

      unique case (st_reg.fsm)
         FILL_IDLE: begin
            if (st_reg.enable) begin
               st_next.fsm      = FILL_RUN;
               st_next.fill_idx = '0;
               st_next.fill_n   = clamp_samples(st_reg.cfg_samples);
            end
         end
         FILL_RUN: begin
            if (!st_reg.enable) begin
               st_next.fsm = FILL_IDLE;
            end else if (wr_en) begin
               st_next.fill_idx = st_reg.fill_idx + 1'b1;
            end
         end
      endcase

      // Completed block becomes the offered one only once its last sample is in
      if (blk_done) begin
         st_next.fill_idx = '0;
         st_next.fill_n   = clamp_samples(st_reg.cfg_samples);
         st_next.seq_ctr  = st_reg.seq_ctr + 1'b1;
         st_next.bank_seq[st_reg.fill_bank] = st_reg.seq_ctr;
         st_next.bank_n[st_reg.fill_bank]   = st_reg.fill_n;
         st_next.ready_bank = st_reg.fill_bank;
         st_next.ready_pend = 1'b1;
         if (st_reg.ready_pend && !i_pdo_fetch) begin
            st_next.drop_ctr = st_reg.drop_ctr + 1'b1;
         end
      end

      if (i_pdo_fetch) begin
         if (st_reg.ready_pend) begin
            st_next.read_bank = old_ready;
            st_next.fresh     = 1'b1;
            if (blk_done) begin
               // Fetch takes the older block, the new one stays pending
               st_next.fill_bank = st_reg.read_bank;
            end else begin
               st_next.ready_pend = 1'b0;
               st_next.ready_bank = st_reg.read_bank;
            end
         end else begin
            st_next.fresh   = 1'b0;
            st_next.rep_ctr = st_reg.rep_ctr + 1'b1;
            if (blk_done) begin
               st_next.fill_bank = old_ready;
            end
         end
      end else if (blk_done) begin
         st_next.fill_bank = old_ready;
      end

      // APB: read data is latched in the setup cycle, shown in the access cycle
      if (apb_rd) begin
         st_next.pslverr = 1'b0;
         unique case (i_paddr)
            ADDR_CTRL: begin
               st_next.prdata = '0;
               st_next.prdata[CTRL_SAMP_LSB +: SAMP_W] = st_reg.cfg_samples;
               st_next.prdata[CTRL_COMM_LSB +: 2]      = st_reg.comm;
               st_next.prdata[CTRL_ERR_LSB +: 3]       = st_reg.err;
               st_next.prdata[CTRL_EN_BIT]             = st_reg.enable;
            end
            ADDR_STATUS: begin
               st_next.prdata = '0;
               st_next.prdata[STAT_SEQ_LSB +: SEQ_W]  = st_reg.seq_ctr;
               st_next.prdata[STAT_IDX_LSB +: SAMP_W] = st_reg.fill_idx;
               st_next.prdata[STAT_PEND_BIT]          = st_reg.ready_pend;
            end
            ADDR_DROPPED: st_next.prdata = 32'(st_reg.drop_ctr);
            ADDR_REPEAT:  st_next.prdata = 32'(st_reg.rep_ctr);
            default: begin
               st_next.prdata  = '0;
               st_next.pslverr = 1'b1;
            end
         endcase
      end else if (i_psel && !i_penable) begin
         st_next.prdata  = '0;
         st_next.pslverr = !(i_paddr == ADDR_CTRL);
      end

      if (apb_wr && (i_paddr == ADDR_CTRL)) begin
         st_next.cfg_samples = i_pwdata[CTRL_SAMP_LSB +: SAMP_W];
         st_next.comm        = osl_comm_t'(i_pwdata[CTRL_COMM_LSB +: 2]);
         st_next.err         = osl_err_t'(i_pwdata[CTRL_ERR_LSB +: 3]);
         st_next.enable      = i_pwdata[CTRL_EN_BIT];
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_reg             <= '0;
         st_reg.fsm         <= FILL_IDLE;
         st_reg.cfg_samples <= CTRL_SAMP_RST;
         st_reg.fill_n      <= SAMP_W'(1);
         st_reg.fill_bank   <= 2'h0;
         st_reg.ready_bank  <= 2'h1;
         st_reg.read_bank   <= 2'h2;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Block storage: three banks so filling never touches the offered or read block
   always_ff @(posedge i_clk) begin
      if (wr_en && st_reg.fsm == FILL_RUN) begin
         mem[word_addr(st_reg.fill_bank, st_reg.fill_idx, 0)] <= i_sample_val0;
         mem[word_addr(st_reg.fill_bank, st_reg.fill_idx, 1)] <= i_sample_val1;
      end
      pdo_data_reg <= mem[ADDR_W'(int'(st_reg.read_bank) * WPB + int'(i_pdo_word))];
   end

   assign o_pdo_data    = pdo_data_reg;
   assign o_pdo_seq     = st_reg.bank_seq[st_reg.read_bank];
   assign o_pdo_samples = st_reg.bank_n[st_reg.read_bank];
   assign o_pdo_fresh   = st_reg.fresh;
   assign o_pready      = 1'b1;
   assign o_prdata      = (i_psel && i_penable) ? st_reg.prdata : '0;
   assign o_pslverr     = i_psel && i_penable && st_reg.pslverr;

   ////////////////////////////////////////////////////////////////////////////
   osl_lamp #(
      .SLOT_CYCLES (SLOT_CYCLES)
   ) u_lamp (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_comm    (st_reg.comm),
      .i_err     (st_reg.err),
      .o_green   (o_lamp_green),
      .o_red     (o_lamp_red)
   );

   ////////////////////////////////////////////////////////////////////////////
   sequence seq_block_done;
      blk_done;
   endsequence

   sequence seq_fetch_pending;
      i_pdo_fetch && st_reg.ready_pend && !blk_done;
   endsequence

   AST_SAMPLE_COUNT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      seq_block_done |=> st_reg.bank_n[st_reg.ready_bank] == $past(st_reg.fill_n)
                         && st_reg.fill_n == clamp_samples($past(st_reg.cfg_samples)))
      else $error("block sample count differs from configuration");
   AST_COMPLETE_ONLY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $rose(st_reg.ready_pend) |-> $past(blk_done))
      else $error("block offered before its last sample");
   AST_DROP_OLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (blk_done && st_reg.ready_pend && !i_pdo_fetch) |=> st_reg.drop_ctr == $past(st_reg.drop_ctr) + 1'b1
                                                        && st_reg.fill_bank == $past(st_reg.ready_bank))
      else $error("uncollected block not replaced");
   AST_FETCH_NEW: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      seq_fetch_pending |=> st_reg.read_bank == $past(st_reg.ready_bank) && !st_reg.ready_pend && o_pdo_fresh)
      else $error("fetch did not take the completed block");
   AST_FETCH_REPEAT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_pdo_fetch && !st_reg.ready_pend) |=> $stable(st_reg.read_bank) && !o_pdo_fresh
                                              && $stable(o_pdo_seq))
      else $error("repeat fetch changed the delivered block");
   AST_BANKS_APART: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      st_reg.fill_bank != st_reg.ready_bank && st_reg.fill_bank != st_reg.read_bank
      && st_reg.ready_bank != st_reg.read_bank)
      else $error("block banks overlap");
   AST_ORDER: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (wr_en && st_reg.fsm == FILL_RUN && !blk_done) |=> st_reg.fill_idx == $past(st_reg.fill_idx) + 1'b1)
      else $error("samples not stored in order");
   AST_SEQ_TAG: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      seq_block_done ##1 seq_fetch_pending |=> o_pdo_seq == $past(st_reg.seq_ctr, 2))
      else $error("delivered block carries wrong counter");

   ////////////////////////////////////////////////////////////////////////////
   // Fill counter and hand-over bookkeeping
   // Counters are checked cycle by cycle, since a lost or doubled block is silent on the bus
   sequence seq_fill_start;
      st_reg.fsm == FILL_IDLE && st_reg.enable;
   endsequence

   sequence seq_pend_idle;
      st_reg.ready_pend && !i_pdo_fetch && !blk_done;
   endsequence

   sequence seq_fetch_empty;
      i_pdo_fetch && !st_reg.ready_pend;
   endsequence

   sequence seq_bad_setup;
      i_psel && !i_penable && (i_paddr != ADDR_CTRL)
      && (i_pwrite || (i_paddr != ADDR_STATUS && i_paddr != ADDR_DROPPED && i_paddr != ADDR_REPEAT));
   endsequence

   AST_FILL_START: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      seq_fill_start |=> st_reg.fsm == FILL_RUN && st_reg.fill_idx == '0
                         && st_reg.fill_n == clamp_samples($past(st_reg.cfg_samples)))
      else $error("block start did not load the sample count");
   AST_FILL_RANGE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      st_reg.fill_idx < st_reg.fill_n && st_reg.fill_n != '0 && st_reg.fill_n <= SAMP_W'(MAX_SAMPLES))
      else $error("fill index outside the block");
   AST_IDLE_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (st_reg.fsm == FILL_IDLE && !st_reg.enable) |=> $stable(st_reg.fill_idx))
      else $error("fill index moved while idle");
   AST_RUN_STOP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (st_reg.fsm == FILL_RUN && !st_reg.enable) |=> st_reg.fsm == FILL_IDLE)
      else $error("filling went on after disable");
   AST_PEND_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      seq_pend_idle |=> st_reg.ready_pend && $stable(st_reg.ready_bank))
      else $error("offered block lost without fetch");
   AST_DROP_ONLY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !(blk_done && st_reg.ready_pend && !i_pdo_fetch) |=> $stable(st_reg.drop_ctr))
      else $error("drop counted without a replaced block");
   AST_REPEAT_COUNT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      seq_fetch_empty |=> st_reg.rep_ctr == $past(st_reg.rep_ctr) + 1'b1)
      else $error("repeat fetch not counted");
   AST_FRESH_SET: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $rose(o_pdo_fresh) |-> $past(i_pdo_fetch && st_reg.ready_pend))
      else $error("fresh flag without a new block");
   AST_SEQ_STEP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      seq_block_done |=> st_reg.seq_ctr == $past(st_reg.seq_ctr) + 1'b1)
      else $error("block counter did not step");
   AST_BAD_ADDR: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      seq_bad_setup ##1 (i_psel && i_penable) |-> o_pslverr && o_prdata == '0)
      else $error("unmapped access not refused");
endmodule : osl_block_framer

// ### pkg/osl_pkg.sv
package osl_pkg;
   // Measurement data layout
   localparam int unsigned VALUE_BYTES       = 4;
   localparam int unsigned VALUES_PER_SAMPLE = 2;
   localparam int unsigned VALUE_W           = VALUE_BYTES * 8;
   localparam int unsigned MAX_SAMPLES_DEF   = 10;
   localparam int unsigned SAMP_W            = 5;
   localparam int unsigned BANKS             = 3;
   localparam int unsigned SEQ_W             = 16;

   // Clock and indicator timing
   localparam longint unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned SLOT_MS           = 50;
   localparam int unsigned SLOT_CYCLES_DEF   = int'((CLK_HZ * SLOT_MS) / 1000);
   localparam int unsigned FLASH_ON_MS       = 200;
   localparam int unsigned SINGLE_OFF_MS     = 1000;
   localparam int unsigned DOUBLE_GAP_MS     = 200;
   localparam int unsigned DOUBLE_OFF_MS     = 400;
   localparam int unsigned BLINK_SLOW_MS     = 200;
   localparam int unsigned BLINK_FAST_MS     = 50;
   localparam int unsigned ON_SLOTS          = FLASH_ON_MS / SLOT_MS;
   localparam int unsigned SINGLE_SLOTS      = (FLASH_ON_MS + SINGLE_OFF_MS) / SLOT_MS;
   localparam int unsigned DOUBLE_SLOTS      = (2 * FLASH_ON_MS + DOUBLE_GAP_MS + DOUBLE_OFF_MS) / SLOT_MS;
   localparam int unsigned DOUBLE_2ND_SLOT   = (FLASH_ON_MS + DOUBLE_GAP_MS) / SLOT_MS;
   localparam int unsigned SLOW_HALF_SLOTS   = BLINK_SLOW_MS / SLOT_MS;
   localparam int unsigned FAST_HALF_SLOTS   = BLINK_FAST_MS / SLOT_MS;
   localparam int unsigned PATTERN_SLOTS     = 120;
   localparam int unsigned SLOT_IDX_W        = 7;
   localparam int unsigned TICK_W            = 24;

   // Register map, byte addresses
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_DROPPED = 8'h08;
   localparam logic [7:0] ADDR_REPEAT  = 8'h0C;

   // Control register fields
   localparam int unsigned CTRL_SAMP_LSB = 0;
   localparam int unsigned CTRL_COMM_LSB = 8;
   localparam int unsigned CTRL_ERR_LSB  = 12;
   localparam int unsigned CTRL_EN_BIT   = 16;
   localparam logic [SAMP_W-1:0] CTRL_SAMP_RST = 5'h0A;

   // Status register fields
   localparam int unsigned STAT_SEQ_LSB   = 0;
   localparam int unsigned STAT_IDX_LSB   = 16;
   localparam int unsigned STAT_PEND_BIT  = 24;

   typedef enum logic [1:0] {
      COMM_INIT   = 2'h0,
      COMM_PREOP  = 2'h1,
      COMM_SAFEOP = 2'h2,
      COMM_OP     = 2'h3
   } osl_comm_t;

   typedef enum logic [2:0] {
      ERR_NONE      = 3'h0,
      ERR_BAD_CFG   = 3'h1,
      ERR_UNREQ     = 3'h2,
      ERR_WATCHDOG  = 3'h3,
      ERR_INIT_FAIL = 3'h4
   } osl_err_t;

   typedef enum logic [1:0] {
      FILL_IDLE = 2'b01,
      FILL_RUN  = 2'b10
   } osl_fill_t;
endpackage : osl_pkg

// ### logic/osl_lamp.sv
module osl_lamp import osl_pkg::*; #(
   parameter int unsigned SLOT_CYCLES = SLOT_CYCLES_DEF
) (
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   input  wire osl_comm_t  i_comm,
   input  wire osl_err_t   i_err,
   output logic            o_green,
   output logic            o_red
);
   typedef struct packed {
      logic [TICK_W-1:0]     tick;
      logic [SLOT_IDX_W-1:0] slot;
      logic                  green;
      logic                  red;
   } osl_lamp_state_t;

   osl_lamp_state_t st_reg, st_next;

   function automatic logic in_window(input int unsigned s, input int unsigned period,
                                      input int unsigned lo, input int unsigned len);
      int unsigned p;
      p = s % period;
      return (p >= lo) && (p < lo + len);
   endfunction : in_window

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic g;
      logic r;
      g = 1'b0;
      r = 1'b0;
      st_next = st_reg;
      if (st_reg.tick == TICK_W'(SLOT_CYCLES - 1)) begin
         st_next.tick = '0;
         st_next.slot = (st_reg.slot == SLOT_IDX_W'(PATTERN_SLOTS - 1)) ? '0 : st_reg.slot + 1'b1;
      end else begin
         st_next.tick = st_reg.tick + 1'b1;
      end
      unique case (i_comm)
         COMM_INIT:   g = 1'b0;
         COMM_PREOP:  g = in_window(st_reg.slot, 2 * SLOW_HALF_SLOTS, 0, SLOW_HALF_SLOTS);
         COMM_SAFEOP: g = in_window(st_reg.slot, SINGLE_SLOTS, 0, ON_SLOTS);
         COMM_OP:     g = 1'b1;
      endcase
      case (i_err)
         ERR_BAD_CFG:   r = in_window(st_reg.slot, 2 * SLOW_HALF_SLOTS, 0, SLOW_HALF_SLOTS);
         ERR_UNREQ:     r = in_window(st_reg.slot, SINGLE_SLOTS, 0, ON_SLOTS);
         ERR_WATCHDOG:  r = in_window(st_reg.slot, DOUBLE_SLOTS, 0, ON_SLOTS)
                            | in_window(st_reg.slot, DOUBLE_SLOTS, DOUBLE_2ND_SLOT, ON_SLOTS);
         ERR_INIT_FAIL: r = in_window(st_reg.slot, 2 * FAST_HALF_SLOTS, 0, FAST_HALF_SLOTS);
         default:       r = 1'b0;
      endcase
      // Red only shows in the dark gaps of green
      st_next.green = g;
      st_next.red   = r & ~g;
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_green = st_reg.green;
   assign o_red   = st_reg.red;

   AST_RED_IN_GAP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !(o_green && o_red)) else $error("red lit together with green");
   AST_GREEN_MODE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ($past(i_comm) == COMM_OP |-> o_green) and ($past(i_comm) == COMM_INIT |-> !o_green))
      else $error("green level wrong for static state");
   AST_SAFEOP_FLASH: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $past(i_comm) == COMM_SAFEOP |-> o_green == (($past(st_reg.slot) % SINGLE_SLOTS) < ON_SLOTS))
      else $error("single flash timing wrong");
   AST_DOUBLE_FLASH: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ($past(i_err) == ERR_WATCHDOG && !o_green && (($past(st_reg.slot) % DOUBLE_SLOTS) >= 2 * ON_SLOTS)
       && (($past(st_reg.slot) % DOUBLE_SLOTS) >= DOUBLE_2ND_SLOT + ON_SLOTS)) |-> !o_red)
      else $error("double flash lit during long gap");
   AST_UNREQ_FLASH: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ($past(i_err) == ERR_UNREQ && $past(i_comm) == COMM_INIT)
      |-> o_red == (($past(st_reg.slot) % SINGLE_SLOTS) < ON_SLOTS))
      else $error("red single flash timing wrong");
endmodule : osl_lamp

// ### test/osl_master_model.sv
module osl_master_model import osl_pkg::*; #(
   parameter int unsigned ADDR_W = 6
) (
   input  wire logic               i_clk,
   output logic                    o_pdo_fetch,
   output logic [ADDR_W-1:0]       o_pdo_word,
   input  wire logic [VALUE_W-1:0] i_pdo_data,
   input  wire logic [SEQ_W-1:0]   i_pdo_seq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [SEQ_W-1:0]   last_seq = '1;
   logic               dup      = 1'b0;
   logic [VALUE_W-1:0] words [0:2*MAX_SAMPLES_DEF-1];
   initial begin
      o_pdo_fetch = 1'b0;
      o_pdo_word  = '0;
   end
   ////////////////////////////////////////////////////////////////
   // One fetch per call; the bench spaces calls, so a slow cycle loses blocks
   task automatic cycle(input int n);
      @(posedge i_clk);
      o_pdo_fetch <= 1'b1;
      @(posedge i_clk);
      o_pdo_fetch <= 1'b0;
      @(posedge i_clk);
      @(negedge i_clk);
      dup      = (i_pdo_seq === last_seq);
      last_seq = i_pdo_seq;
      for (int k = 0; k < n; k++) begin
         @(posedge i_clk);
         o_pdo_word <= ADDR_W'(k);
         @(posedge i_clk);
         @(negedge i_clk);
         words[k] = i_pdo_data;
      end
   endtask : cycle
endmodule : osl_master_model

// ### test/tb_top.sv
module tb_top import osl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned AW = $clog2(BANKS * MAX_SAMPLES_DEF * VALUES_PER_SAMPLE);
   localparam int unsigned SC = 4;
   logic               clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, svalid = 1'b0;
   logic [7:0]         paddr = '0;
   logic [31:0]        pwdata = '0, sval0 = '0, sval1 = '0, prdata, rd;
   logic               pready, pslverr, fetch, fresh, green, red, err;
   logic [AW-1:0]      word;
   logic [VALUE_W-1:0] pdata;
   logic [SEQ_W-1:0]   seq;
   logic [SAMP_W-1:0]  nsamp;
   int                 n_mismatch = 0, checks_done = 0, cyc = 0;
   always #20 clk = ~clk;
   // Short slots keep a full lamp pattern to 480 cycles
   osl_block_framer #(.SLOT_CYCLES(SC)) i_osl_block_framer (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_sample_valid(svalid), .i_sample_val0(sval0),
      .i_sample_val1(sval1), .i_pdo_fetch(fetch), .i_pdo_word(word), .o_pdo_data(pdata), .o_pdo_seq(seq),
      .o_pdo_samples(nsamp), .o_pdo_fresh(fresh), .o_lamp_green(green), .o_lamp_red(red));
   osl_master_model #(.ADDR_W(AW)) i_osl_master_model (.i_clk(clk), .o_pdo_fetch(fetch), .o_pdo_word(word),
      .i_pdo_data(pdata), .i_pdo_seq(seq));
   ////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   always @(posedge clk) begin
      cyc++;
      if (cyc == 12000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [31:0] ctrl(input osl_comm_t c, input osl_err_t e);
      return 32'h2 | (32'(c) << CTRL_COMM_LSB) | (32'(e) << CTRL_ERR_LSB) | (32'h1 << CTRL_EN_BIT);
   endfunction : ctrl
   task automatic put(input int k);
      @(posedge clk);
      svalid <= 1'b1;
      sval0  <= 32'hA000_0000 + k;
      sval1  <= 32'hB000_0000 + k;
      @(posedge clk);
      svalid <= 1'b0;
   endtask : put
   task automatic blk(input int n, input int k0, input logic [15:0] s, input logic f);
      i_osl_master_model.cycle(2 * n);
      chk(fresh, f);
      chk(seq, s);
      chk(nsamp, n);
      chk(i_osl_master_model.dup, !f);
      for (int j = 0; j < 2 * n; j++) chk(i_osl_master_model.words[j], (j % 2 ? 32'hB000_0000 : 32'hA000_0000) + k0 + j / 2);
   endtask : blk
   ////////////////////////////////////////////////////////////////
   task automatic t_regs();
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h0000_000A);
      apb(1'b0, 8'h10, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
      chk(err, 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h0);
   endtask : t_regs
   task automatic t_block();
      apb(1'b1, ADDR_CTRL, ctrl(COMM_OP, ERR_NONE));
      chk(err, 1'b0);
      put(0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd & 32'h011F_FFFF, 32'h0001_0000);
      put(1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd & 32'h0100_FFFF, 32'h0100_0001);
      blk(2, 0, 16'h0, 1'b1);
      blk(2, 0, 16'h0, 1'b0);
      apb(1'b0, ADDR_REPEAT, 32'h0);
      chk(rd, 32'h1);
   endtask : t_block
   task automatic t_drop();
      for (int k = 2; k < 6; k++) put(k);
      apb(1'b0, ADDR_DROPPED, 32'h0);
      chk(rd, 32'h1);
      blk(2, 4, 16'h2, 1'b1);
   endtask : t_drop
   // Whole patterns only, so counts do not depend on the start phase
   task automatic lamp(input osl_comm_t c, input osl_err_t e, input int eg, input int er, input int ec);
      int g = 0, r = 0, both = 0, chg = 0;
      logic pg, pr;
      apb(1'b1, ADDR_CTRL, ctrl(c, e));
      repeat (16) @(posedge clk);
      @(negedge clk);
      pg = green;
      pr = red;
      repeat (PATTERN_SLOTS * SC) begin
         @(negedge clk);
         g += int'(green === 1'b1);
         r += int'(red === 1'b1);
         both += int'(green !== 1'b0 && red !== 1'b0);
         chg += int'(green !== pg) + int'(red !== pr);
         pg = green;
         pr = red;
      end
      chk(g, eg);
      chk(both, 0);
      if (er >= 0) chk(r, er);
      if (ec >= 0) chk(chg, ec);
   endtask : lamp
   task automatic t_lamp();
      lamp(COMM_INIT, ERR_NONE, 0, 0, 0);
      lamp(COMM_PREOP, ERR_NONE, 240, 0, 30);
      lamp(COMM_OP, ERR_BAD_CFG, 480, 0, 0);
      lamp(COMM_SAFEOP, ERR_WATCHDOG, 80, -1, -1);
      lamp(COMM_INIT, ERR_BAD_CFG, 0, 240, 30);
      lamp(COMM_INIT, ERR_INIT_FAIL, 0, 240, 120);
      lamp(COMM_INIT, ERR_UNREQ, 0, 80, 10);
      lamp(COMM_INIT, ERR_WATCHDOG, 0, 192, 24);
   endtask : t_lamp
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_block();
      t_drop();
      t_lamp();
      give_verdict();
   end
endmodule : tb_top
